/* rtl/sipo_pkg.sv */
/*
 Constants for the serial-in, parallel-out latch block.
 Assumes a single system clock of 50 MHz; no other dependencies.
*/
package sipo_pkg;
  localparam int          STAGES     = 8;
  localparam logic [7:0]  SHIFT_RST  = 8'h00;
  localparam logic [7:0]  STORE_RST  = 8'h00;
  localparam int          SYNC_DEPTH = 3;
  localparam int          FIRST_POS  = 0;
endpackage

/* rtl/pin_sync.sv */
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes the input is asynchronous to clock_i.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Pin and result
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] sync_ff;
  logic [2:0] nxt_sync;
  logic       level_ff;
  logic       nxt_level;

  always_comb begin
    nxt_sync  = {sync_ff[1:0], pin_i};
    nxt_level = level_ff;
    // First stage feeds only the second
    if (sync_ff[1] == sync_ff[2]) begin
      nxt_level = sync_ff[2];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_ff  <= 3'h0;
      level_ff <= 1'b0;
    end else begin
      sync_ff  <= nxt_sync;
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;
endmodule
`default_nettype wire

/* rtl/sipo_latch.sv */
/*
 Serial-in, parallel-out shift register feeding a storage register
 with three-state parallel outputs, sampled on one system clock.
 Assumes all pins come from outside the clock domain; pin clocks
 must stay each level for several system clock periods.
*/
// Summary of operation
// - Output enable high releases all eight parallel outputs.
// - Output enable low drives storage contents on parallel outputs.
// - Clear low forces every shift stage to zero.
// - Shift edge with serial input low loads zero into stage one.
// - Shift edge with serial input high loads one into stage one.
// - Each later stage takes previous value of the stage before.
// - Storage edge copies all shift stages into storage register.
// - Clear overrides shift clock and leaves storage untouched.
// - Besides reset, only clear and rising edges of either clock change shift or storage.
// - Last stage is exported for chaining devices.
// - Common clock makes storage lag shift by one step.
`timescale 1ns/1ns
`default_nettype none
module sipo_latch
  import sipo_pkg::*;
#(
  parameter int WIDTH = STAGES
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // Host pins
  input  wire logic             serial_data_in_i,
  input  wire logic             shift_clock_i,
  input  wire logic             store_clock_i,
  input  wire logic             shift_clear_n_i,
  input  wire logic             output_enable_n_i,
  // Parallel outputs, three-state as value plus enable
  output logic [WIDTH-1:0]      parallel_out_o,
  output logic [WIDTH-1:0]      parallel_oe_o,
  // Chaining output
  output logic                  cascade_serial_out_o
);

  //****************************************
  // Pin synchronisers
  //****************************************
  logic [4:0] pins_raw;
  logic [4:0] pins_s;
  // Active-low pins inverted first, so a synchroniser in reset reads idle
  assign pins_raw = {~output_enable_n_i, ~shift_clear_n_i, store_clock_i,
                     shift_clock_i, serial_data_in_i};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      pin_sync u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .pin_i   (pins_raw[gi]),
        .level_o (pins_s[gi])
      );
    end
  endgenerate

  logic data_s;
  logic shift_clk_s;
  logic store_clk_s;
  logic clr_n_s;
  logic oe_n_s;
  assign data_s      = pins_s[0];
  assign shift_clk_s = pins_s[1];
  assign store_clk_s = pins_s[2];
  assign clr_n_s     = ~pins_s[3];
  assign oe_n_s      = ~pins_s[4];

  //****************************************
  // Edge detection
  //****************************************
  // Shared by both pin clocks
  function automatic logic rise_of(input logic now_lvl,
                                   input logic old_lvl);
    return now_lvl & ~old_lvl;
  endfunction

  logic shift_clk_ff;
  logic nxt_shift_clk;
  logic store_clk_ff;
  logic nxt_store_clk;
  logic shift_clk_rise;
  logic store_clk_rise;

  always_comb begin
    nxt_shift_clk  = shift_clk_s;
    nxt_store_clk  = store_clk_s;
    shift_clk_rise = rise_of(shift_clk_s, shift_clk_ff);
    store_clk_rise = rise_of(store_clk_s, store_clk_ff);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_clk_ff <= 1'b0;
      store_clk_ff <= 1'b0;
    end else begin
      shift_clk_ff <= nxt_shift_clk;
      store_clk_ff <= nxt_store_clk;
    end
  end

  //****************************************
  // Shift register
  //****************************************
  // Clear is sampled like other pins; it acts within sync latency
  // rather than truly asynchronously, traded for a glitch-free domain.
  logic [WIDTH-1:0] shift_ff;
  logic [WIDTH-1:0] nxt_shift;

  always_comb begin
    nxt_shift = shift_ff;
    if (!clr_n_s) begin
      nxt_shift = WIDTH'(SHIFT_RST);
    end else if (shift_clk_rise) begin
      // Newest bit enters at the bottom, the rest move up
      nxt_shift = {shift_ff[WIDTH-2:0], data_s};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_ff <= WIDTH'(SHIFT_RST);
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  //****************************************
  // Storage register
  //****************************************
  logic [WIDTH-1:0] store_ff;
  logic [WIDTH-1:0] nxt_store;

  always_comb begin
    nxt_store = store_ff;
    // Old shift contents captured, so common clock lags one step
    if (store_clk_rise) begin
      nxt_store = shift_ff;
    end
  end

  // Clear never reaches here, so the shown word survives a clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      store_ff <= WIDTH'(STORE_RST);
    end else begin
      store_ff <= nxt_store;
    end
  end

  //****************************************
  // Output stage
  //****************************************
  logic [WIDTH-1:0] pout_ff;
  logic [WIDTH-1:0] nxt_pout;
  logic [WIDTH-1:0] poe_ff;
  logic [WIDTH-1:0] nxt_poe;
  logic             casc_ff;
  logic             nxt_casc;

  always_comb begin
    // Fed from next values so outputs land with their registers
    nxt_pout = nxt_store;
    nxt_poe  = {WIDTH{~oe_n_s}};
    // Cascade ignores output enable; only parallel pins float
    nxt_casc = nxt_shift[WIDTH-1];
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pout_ff <= WIDTH'(STORE_RST);
      poe_ff  <= '0;
      casc_ff <= 1'b0;
    end else begin
      pout_ff <= nxt_pout;
      poe_ff  <= nxt_poe;
      casc_ff <= nxt_casc;
    end
  end

  assign parallel_out_o       = pout_ff;
  assign parallel_oe_o        = poe_ff;
  assign cascade_serial_out_o = casc_ff;

  //****************************************
  // Checks
  //****************************************
  clear_zero_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !clr_n_s |=> shift_ff == '0)
    else $error("shift register not cleared");

  shift_in_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    clr_n_s && shift_clk_rise |=> shift_ff[FIRST_POS] == $past(data_s))
    else $error("first stage did not take serial input");

  shift_move_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    clr_n_s && shift_clk_rise |=>
      shift_ff[WIDTH-1:1] == $past(shift_ff[WIDTH-2:0]))
    else $error("stages did not move along");

  no_edge_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    clr_n_s && !shift_clk_rise |=> $stable(shift_ff))
    else $error("shift changed without rising edge");

  store_copy_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    store_clk_rise |=> store_ff == $past(shift_ff))
    else $error("storage did not copy shift stages");

  store_hold_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !store_clk_rise |=> $stable(store_ff))
    else $error("storage changed without its edge");

  store_clear_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !clr_n_s && !store_clk_rise |=> $stable(store_ff))
    else $error("clear disturbed storage");

  out_release_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    oe_n_s |=> parallel_oe_o == '0)
    else $error("outputs driven while disabled");

  out_drive_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !oe_n_s |=> parallel_oe_o == '1 && parallel_out_o == store_ff)
    else $error("outputs not showing storage");

  cascade_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    cascade_serial_out_o == shift_ff[WIDTH-1])
    else $error("cascade output not last stage");

  cascade_clear_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !clr_n_s |=> !cascade_serial_out_o)
    else $error("cascade output not zero after clear");
endmodule
`default_nettype wire

/* testbench/host_model.sv */
/*
 Host model that drives the latch pins in slow, whole steps.
 Assumes clock_i is the system clock of the block under test.
*/
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock
  input  wire logic clock_i,
  // Pins towards the block
  output logic      serial_data_o,
  output logic      shift_clock_o,
  output logic      store_clock_o,
  output logic      shift_clear_n_o,
  output logic      output_enable_n_o
);
  // ******************
  // Pin sequencing
  // ******************
  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // Six cycles a level, three times the two agreeing samples the pin filter needs
  task automatic pulse(input logic sh, input logic st, input logic d);
    serial_data_o = d;
    idle(6);
    shift_clock_o = sh;
    store_clock_o = st;
    idle(6);
    shift_clock_o = 1'b0;
    store_clock_o = 1'b0;
    idle(6);
  endtask
  task automatic levels(input logic clr_n, input logic oe_n);
    shift_clear_n_o   = clr_n;
    output_enable_n_o = oe_n;
    idle(8);
  endtask
  initial begin
    serial_data_o     = 1'b0;
    shift_clock_o     = 1'b0;
    store_clock_o     = 1'b0;
    shift_clear_n_o   = 1'b1;
    output_enable_n_o = 1'b1;
  end
endmodule
`default_nettype wire

/* testbench/sipo_latch_tb.sv */
/*
 Self-checking bench for the shift and storage latch.
 Assumes the host model drives every pin of the block.
*/
`timescale 1ns/1ns
`default_nettype none
module sipo_latch_tb;
  import sipo_pkg::*;
  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  wire        sd, sc, st, clr_n, oe_n, casc;
  wire  [7:0] pout, poe;
  int         failures = 0;
  int         comparisons = 0;
  int         cycles = 0;
  always #10 clock_i = ~clock_i;
  host_model host (.clock_i(clock_i), .serial_data_o(sd),
    .shift_clock_o(sc), .store_clock_o(st), .shift_clear_n_o(clr_n),
    .output_enable_n_o(oe_n));
  sipo_latch i_sipo_latch (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .serial_data_in_i(sd), .shift_clock_i(sc), .store_clock_i(st),
    .shift_clear_n_i(clr_n), .output_enable_n_i(oe_n),
    .parallel_out_o(pout), .parallel_oe_o(poe),
    .cascade_serial_out_o(casc));
  // ******************
  // Checking and ending
  // ******************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Far above the roughly 300 cycles the run needs
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end
  // ******************
  // Scenarios
  // ******************
  task automatic load_show(input logic [7:0] pat);
    for (int i = 7; i >= 0; i--) host.pulse(1'b1, 1'b0, pat[i]);
    check({7'h00, casc}, {7'h00, pat[7]});
    host.pulse(1'b0, 1'b1, 1'b0);
    host.levels(1'b1, 1'b0);
    check(pout, pat);
    check(poe, 8'hff);
  endtask
  task automatic release_out;
    host.levels(1'b1, 1'b1);
    check(poe, 8'h00);
    check({7'h00, casc}, 8'h01);
    host.levels(1'b1, 1'b0);
  endtask
  task automatic clear_shift;
    host.levels(1'b0, 1'b0);
    host.pulse(1'b1, 1'b0, 1'b1);
    check({7'h00, casc}, 8'h00);
    check(pout, 8'ha5);
    host.levels(1'b1, 1'b0);
    host.pulse(1'b0, 1'b1, 1'b0);
    check(pout, 8'h00);
  endtask
  task automatic common_clock;
    host.pulse(1'b1, 1'b1, 1'b1);
    check(pout, 8'h00);
    host.pulse(1'b1, 1'b1, 1'b1);
    check(pout, 8'h01);
    host.pulse(1'b0, 1'b1, 1'b0);
    check(pout, 8'h03);
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    #1;
    check(pout, 8'h00);
    check(poe, 8'h00);
    rst_n_i = 1'b1;
    host.idle(4);
    check(poe, 8'h00);
    check({7'h00, casc}, 8'h00);
    load_show(8'ha5);
    release_out();
    clear_shift();
    common_clock();
    end_sim();
  end
endmodule
`default_nettype wire
